// File: src/dual_timers.sv
/*
  Two general timers behind an AHB-Lite slave: a 16-bit down counter and a
  32-bit up/down counter with time format and event capture.
  Assumes all inputs, including the slow clock sources, are synchronous to
  clk; the slow sources are used as levels whose rising edges count.
*/
// Our own choice: register access over AHB-Lite.
`timescale 1ns/100ps

// Notes on behaviour
// - Timer A is a 16-bit down counter behind a prescaler.
// - Timer A prescale bits 3:2 divide by 1, 16, 256; code 11 acts as 00.
// - Timer A source bits 5:4: core, second clock, 32768 Hz oscillator; 11 none.
// - Timer A control bit 7 enables counting; reset cleared.
// - Timer A control bit 6 picks periodic, else free-running.
// - Timer A load register is 16-bit read/write, reset zero.
// - Timer A value register is read-only, shows the counter, resets to 0xFFFF.
// - Any write to timer A clear register drops its pending interrupt.
// - Timer B is a 32-bit up or down counter behind a prescaler.
// - Timer B prescale bits 3:0 divide by 1, 16, 256, 32768.
// - Timer B source bits 11:9: core, oscillator, second clock, pin rising edge.
// - Timer B control bit 8 counts up when set, down when clear.
// - Timer B bit 7 enables, bit 6 picks periodic; both reset cleared.
// - Timer B format bits 5:4: binary, reserved, time 23 hours, time 255 hours.
// - Time word: hours 31:24, minutes 21:16, seconds 13:8, fraction 6:0.
// - Fraction counts 0 to 127; minutes and seconds 0 to 59.
// - Load and value registers share the time layout.
// - Timer B bit 17 enables capture; bits 16:12 pick one of 32 events.
// - Each rising edge of the picked event copies the counter into capture.
// - Timer B load register is 32-bit read/write, reset zero.
// - Timer B value register is read-only and shows the counter.
// - Each timer drives a converter start trigger.
// - Periodic restarts from load at the end; free-running wraps around.
// - Interrupt each time the counter reaches zero down or full scale up.
// - Any write to timer B clear register drops its interrupt.
// - Timer B capture register is 32-bit read-only, reset zero.
module dual_timers
  import dual_timers_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Count sources
  input  wire logic        second_system_clock,
  input  wire logic        osc_32k,
  input  wire logic        external_count_pin,
  // Capture event sources
  input  wire logic [31:0] event_sources,
  // Interrupts and converter triggers
  output logic             irq_a,
  output logic             irq_b,
  output logic             adc_trig_a,
  output logic             adc_trig_b
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [15:0] a_load;
    logic [15:0] a_val;
    logic [15:0] a_ctl;
    logic [14:0] a_pre;
    logic        a_irq;
    logic        a_trig;
    logic [31:0] b_load;
    logic [31:0] b_val;
    logic [31:0] b_ctl;
    logic [14:0] b_pre;
    logic        b_irq;
    logic        b_trig;
    logic [31:0] b_cap;
    logic [31:0] evt_prev;
    logic        sec_prev;
    logic        osc_prev;
    logic        pin_prev;
    logic        wr_pend;
    logic [31:0] wr_addr;
    logic [31:0] rdata;
    logic        ready;
  } state_s;

  state_s      st_q;
  state_s      st_d;
  logic        sec_edge;
  logic        osc_edge;
  logic        pin_edge;
  logic        ap_valid;
  logic        a_src;
  logic [14:0] a_last;
  logic        a_tick;
  logic [15:0] a_next;
  logic        a_evt;
  logic        a_clr;
  logic        b_src;
  logic [14:0] b_last;
  logic        b_tick;
  logic        b_time;
  logic [7:0]  b_hmax;
  logic [31:0] b_full;
  logic [31:0] b_term;
  logic [31:0] b_step;
  logic [31:0] b_next;
  logic        b_evt;
  logic        b_clr;
  logic        b_hit;

  // ==========================================================================
  // Next state
  always_comb begin
    st_d = st_q;
    a_clr = 1'b0;
    b_clr = 1'b0;
    // Slow sources count on rising edges sampled in the core domain
    sec_edge = second_system_clock & ~st_q.sec_prev;
    osc_edge = osc_32k & ~st_q.osc_prev;
    pin_edge = external_count_pin & ~st_q.pin_prev;
    st_d.sec_prev = second_system_clock;
    st_d.osc_prev = osc_32k;
    st_d.pin_prev = external_count_pin;

    // Timer A source and prescaler
    unique case (st_q.a_ctl[A_SRC_LSB +: 2])
      A_SRC_CORE: a_src = 1'b1;
      A_SRC_SEC:  a_src = sec_edge;
      A_SRC_OSC:  a_src = osc_edge;
      default:    a_src = 1'b0;
    endcase
    unique case (st_q.a_ctl[A_PRE_LSB +: 2])
      A_PRE_16:  a_last = DIV16_LAST;
      A_PRE_256: a_last = DIV256_LAST;
      default:   a_last = DIV1_LAST;
    endcase
    a_tick = st_q.a_ctl[CTL_EN] && a_src && (st_q.a_pre == a_last);
    if (st_q.a_ctl[CTL_EN] && a_src) begin
      st_d.a_pre = (st_q.a_pre == a_last) ? DIV1_LAST : st_q.a_pre + 15'h0001;
    end
    // Down count; free-running wraps 0 to 0xFFFF by plain subtraction
    a_next = (st_q.a_ctl[CTL_PER] && st_q.a_val == 16'h0000) ? st_q.a_load
                                                             : st_q.a_val - 16'h0001;
    a_evt = a_tick && (a_next == 16'h0000);
    if (a_tick) begin
      st_d.a_val = a_next;
    end

    // Timer B source and prescaler
    unique case (st_q.b_ctl[B_SRC_LSB +: 3])
      B_SRC_CORE: b_src = 1'b1;
      B_SRC_OSC:  b_src = osc_edge;
      B_SRC_SEC:  b_src = sec_edge;
      B_SRC_PIN:  b_src = pin_edge;
      default:    b_src = 1'b0;
    endcase
    unique case (st_q.b_ctl[B_PRE_LSB +: 4])
      B_PRE_16:  b_last = DIV16_LAST;
      B_PRE_256: b_last = DIV256_LAST;
      B_PRE_32K: b_last = DIV32K_LAST;
      default:   b_last = DIV1_LAST;
    endcase
    b_tick = st_q.b_ctl[CTL_EN] && b_src && (st_q.b_pre == b_last);
    if (st_q.b_ctl[CTL_EN] && b_src) begin
      st_d.b_pre = (st_q.b_pre == b_last) ? DIV1_LAST : st_q.b_pre + 15'h0001;
    end
    // Format code 01 is reserved and counts as binary
    b_time = st_q.b_ctl[B_FMT_LSB + 1];
    b_hmax = (st_q.b_ctl[B_FMT_LSB +: 2] == FMT_H23) ? HOUR_23 : HOUR_255;
    b_full = b_time ? {b_hmax, 2'b00, MINSEC_MAX, 2'b00, MINSEC_MAX, 1'b0, FRAC_MAX}
                    : 32'hFFFF_FFFF;
    b_term = st_q.b_ctl[B_UP] ? b_full : 32'h0000_0000;
    if (b_time) begin
      b_step = time_step(st_q.b_val, st_q.b_ctl[B_UP], b_hmax);
    end else if (st_q.b_ctl[B_UP]) begin
      b_step = st_q.b_val + 32'h0000_0001;
    end else begin
      b_step = st_q.b_val - 32'h0000_0001;
    end
    b_hit = st_q.b_val == b_term;
    b_next = (st_q.b_ctl[CTL_PER] && b_hit) ? st_q.b_load : b_step;
    b_evt = b_tick && (b_next == b_term);
    if (b_tick) begin
      st_d.b_val = b_next;
    end

    // Capture on the rising edge of the picked event
    st_d.evt_prev = event_sources;
    if (st_q.b_ctl[B_CAP_EN] && event_sources[st_q.b_ctl[B_EVT_LSB +: 5]]
        && !st_q.evt_prev[st_q.b_ctl[B_EVT_LSB +: 5]]) begin
      st_d.b_cap = st_q.b_val;
    end

    // Bus write data phase; a control write with enable set restarts from load
    if (st_q.wr_pend) begin
      unique case (st_q.wr_addr)
        A_LOAD_ADDR: st_d.a_load = hwdata[15:0];
        A_CTL_ADDR: begin
          st_d.a_ctl = hwdata[15:0] & A_CTL_MASK;
          if (hwdata[CTL_EN]) begin
            st_d.a_val = st_q.a_load;
            st_d.a_pre = DIV1_LAST;
          end
        end
        A_CLR_ADDR:  a_clr = 1'b1;
        B_LOAD_ADDR: st_d.b_load = hwdata;
        B_CTL_ADDR: begin
          st_d.b_ctl = hwdata & B_CTL_MASK;
          if (hwdata[CTL_EN]) begin
            st_d.b_val = st_q.b_load;
            st_d.b_pre = DIV1_LAST;
          end
        end
        B_CLR_ADDR:  b_clr = 1'b1;
        default:     st_d.wr_pend = 1'b0;
      endcase
    end

    // A new event wins over a clear in the same cycle
    st_d.a_irq = (st_q.a_irq & ~a_clr) | a_evt;
    st_d.b_irq = (st_q.b_irq & ~b_clr) | b_evt;
    st_d.a_trig = a_evt;
    st_d.b_trig = b_evt;

    // Address phase: zero wait states, read data set up for the data phase
    ap_valid = hsel && htrans[HTRANS_ACT] && hready;
    st_d.wr_pend = ap_valid && hwrite;
    st_d.wr_addr = haddr;
    st_d.rdata = 32'h0000_0000;
    if (ap_valid && !hwrite) begin
      unique case (haddr)
        A_LOAD_ADDR: st_d.rdata = {16'h0000, st_q.a_load};
        A_VAL_ADDR:  st_d.rdata = {16'h0000, st_q.a_val};
        A_CTL_ADDR:  st_d.rdata = {16'h0000, st_q.a_ctl};
        B_LOAD_ADDR: st_d.rdata = st_q.b_load;
        B_VAL_ADDR:  st_d.rdata = st_q.b_val;
        B_CTL_ADDR:  st_d.rdata = st_q.b_ctl;
        B_CAP_ADDR:  st_d.rdata = st_q.b_cap;
        default:     st_d.rdata = 32'h0000_0000;
      endcase
    end
    st_d.ready = 1'b1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{a_val: A_VAL_RST, b_val: B_VAL_RST, ready: 1'b1, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign hrdata     = st_q.rdata;
  assign hreadyout  = st_q.ready;
  assign hresp      = 1'b0;
  assign irq_a      = st_q.a_irq;
  assign irq_b      = st_q.b_irq;
  assign adc_trig_a = st_q.a_trig;
  assign adc_trig_b = st_q.b_trig;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_a_div16;
    (a_tick && st_q.a_ctl[A_PRE_LSB +: 2] == A_PRE_16 && !st_q.wr_pend)
      |=> (!a_tick) [*8];
  endproperty
  a_a_div16: assert property (p_a_div16) else $error("timer A divides too fast");

  property p_a_stopped;
    (!st_q.a_ctl[CTL_EN] && !st_q.wr_pend) |=> $stable(st_q.a_val);
  endproperty
  a_a_stopped: assert property (p_a_stopped) else $error("timer A moved while off");

  property p_a_irq;
    a_evt |=> irq_a && adc_trig_a ##1 !adc_trig_a || a_evt;
  endproperty
  a_a_irq: assert property (p_a_irq) else $error("timer A zero gave no irq");

  property p_a_clear;
    (st_q.wr_pend && st_q.wr_addr == A_CLR_ADDR && !a_evt) |=> !irq_a;
  endproperty
  a_a_clear: assert property (p_a_clear) else $error("timer A irq not cleared");

  property p_a_reload;
    (a_tick && st_q.a_ctl[CTL_PER] && st_q.a_val == 16'h0000 && !st_q.wr_pend)
      |=> st_q.a_val == $past(st_q.a_load);
  endproperty
  a_a_reload: assert property (p_a_reload) else $error("timer A no reload");

  property p_b_up;
    (b_tick && st_q.b_ctl[B_UP] && !b_time && !b_hit && !st_q.wr_pend)
      |=> st_q.b_val == $past(st_q.b_val) + 32'h0000_0001;
  endproperty
  a_b_up: assert property (p_b_up) else $error("timer B up step wrong");

  property p_b_frac;
    (b_tick && b_time && !st_q.b_ctl[B_UP] && st_q.b_val[6:0] == 7'h00
     && st_q.b_val[13:8] != 6'h00 && st_q.b_val[13:8] <= MINSEC_MAX
     && !b_hit && !st_q.wr_pend)
      |=> st_q.b_val[6:0] == FRAC_MAX && st_q.b_val[13:8] == $past(st_q.b_val[13:8]) - 6'h01;
  endproperty
  a_b_frac: assert property (p_b_frac) else $error("timer B time borrow wrong");

  property p_b_cap;
    (st_q.b_ctl[B_CAP_EN] && $rose(event_sources[st_q.b_ctl[B_EVT_LSB +: 5]]))
      |-> ##1 st_q.b_cap == $past(st_q.b_val);
  endproperty
  a_b_cap: assert property (p_b_cap) else $error("timer B capture missed");

  property p_ctl_rsvd;
    (ap_valid && !hwrite && haddr == A_CTL_ADDR)
      |=> hrdata[15:8] == 8'h00 && hrdata[1:0] == 2'b00;
  endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("reserved bits read nonzero");

  property p_b_clear;
    (st_q.wr_pend && st_q.wr_addr == B_CLR_ADDR && !b_evt) |=> !irq_b;
  endproperty
  a_b_clear: assert property (p_b_clear) else $error("timer B irq not cleared");

  property p_b_irq;
    b_evt |=> irq_b && adc_trig_b;
  endproperty
  a_b_irq: assert property (p_b_irq) else $error("timer B terminal gave no irq");

  c_a_irq:    cover property (a_evt ##1 irq_a);
  c_b_cap:    cover property (st_q.b_ctl[B_CAP_EN] ##1 $changed(st_q.b_cap));
  c_b_time:   cover property (b_tick && b_time && b_hit);
  c_a_reload: cover property (a_tick && st_q.a_ctl[CTL_PER] && st_q.a_val == 16'h0000);
  c_b_pin:    cover property (b_tick && st_q.b_ctl[B_SRC_LSB +: 3] == B_SRC_PIN);

endmodule // dual_timers

// File: src/dual_timers_pkg.sv
/*
  Package for the dual general timers: register byte addresses, control
  field positions and codes, reset values, prescaler end counts and the
  time-format step function.
  Assumes a 32-bit AHB-Lite bus with one aligned word per register.
*/
package dual_timers_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [31:0] A_LOAD_ADDR  = 32'hFFFF_0300;
  localparam logic [31:0] A_VAL_ADDR   = 32'hFFFF_0304;
  localparam logic [31:0] A_CTL_ADDR   = 32'hFFFF_0308;
  localparam logic [31:0] A_CLR_ADDR   = 32'hFFFF_030C;
  localparam logic [31:0] B_LOAD_ADDR  = 32'hFFFF_0320;
  localparam logic [31:0] B_VAL_ADDR   = 32'hFFFF_0324;
  localparam logic [31:0] B_CTL_ADDR   = 32'hFFFF_0328;
  localparam logic [31:0] B_CLR_ADDR   = 32'hFFFF_032C;
  localparam logic [31:0] B_CAP_ADDR   = 32'hFFFF_0330;

  // ==========================================================================
  // Reset values and writable-bit masks
  localparam logic [15:0] A_VAL_RST    = 16'hFFFF;
  localparam logic [31:0] B_VAL_RST    = 32'h0FFF_FFFF;
  localparam logic [15:0] A_CTL_MASK   = 16'h00FC;
  localparam logic [31:0] B_CTL_MASK   = 32'h0003_FFFF;

  // ==========================================================================
  // Control field positions
  localparam int CTL_EN     = 7;
  localparam int CTL_PER    = 6;
  localparam int A_PRE_LSB  = 2;
  localparam int A_SRC_LSB  = 4;
  localparam int B_PRE_LSB  = 0;
  localparam int B_FMT_LSB  = 4;
  localparam int B_UP       = 8;
  localparam int B_SRC_LSB  = 9;
  localparam int B_EVT_LSB  = 12;
  localparam int B_CAP_EN   = 17;
  localparam int HTRANS_ACT = 1;

  // ==========================================================================
  // Field codes
  localparam logic [1:0] A_PRE_16   = 2'h1;
  localparam logic [1:0] A_PRE_256  = 2'h2;
  localparam logic [1:0] A_SRC_CORE = 2'h0;
  localparam logic [1:0] A_SRC_SEC  = 2'h1;
  localparam logic [1:0] A_SRC_OSC  = 2'h2;
  localparam logic [3:0] B_PRE_16   = 4'h4;
  localparam logic [3:0] B_PRE_256  = 4'h8;
  localparam logic [3:0] B_PRE_32K  = 4'hF;
  localparam logic [2:0] B_SRC_CORE = 3'h0;
  localparam logic [2:0] B_SRC_OSC  = 3'h1;
  localparam logic [2:0] B_SRC_SEC  = 3'h2;
  localparam logic [2:0] B_SRC_PIN  = 3'h3;
  localparam logic [1:0] FMT_H23    = 2'h2;
  localparam logic [1:0] FMT_H255   = 2'h3;

  // ==========================================================================
  // Prescaler end counts (divide by N ends at N-1)
  localparam logic [14:0] DIV1_LAST   = 15'h0000;
  localparam logic [14:0] DIV16_LAST  = 15'h000F;
  localparam logic [14:0] DIV256_LAST = 15'h00FF;
  localparam logic [14:0] DIV32K_LAST = 15'h7FFF;

  // ==========================================================================
  // Time format limits
  localparam logic [6:0] FRAC_MAX   = 7'h7F;
  localparam logic [5:0] MINSEC_MAX = 6'h3B;
  localparam logic [7:0] HOUR_23    = 8'h17;
  localparam logic [7:0] HOUR_255   = 8'hFF;

  // One step of the split hours:minutes:seconds:fraction word
  function automatic logic [31:0] time_step(input logic [31:0] v, input logic up,
                                            input logic [7:0] hmax);
    logic [7:0] h;
    logic [5:0] m;
    logic [5:0] s;
    logic [6:0] f;
    h = v[31:24];
    m = v[21:16];
    s = v[13:8];
    f = v[6:0];
    if (up) begin
      if (f != FRAC_MAX) f = f + 7'h01;
      else begin
        f = '0;
        if (s < MINSEC_MAX) s = s + 6'h01;
        else begin
          s = '0;
          if (m < MINSEC_MAX) m = m + 6'h01;
          else begin
            m = '0;
            h = (h >= hmax) ? 8'h00 : h + 8'h01;
          end
        end
      end
    end else begin
      if (f != 7'h00) f = f - 7'h01;
      else begin
        f = FRAC_MAX;
        if (s != 6'h00) s = (s > MINSEC_MAX) ? MINSEC_MAX : s - 6'h01;
        else begin
          s = MINSEC_MAX;
          if (m != 6'h00) m = (m > MINSEC_MAX) ? MINSEC_MAX : m - 6'h01;
          else begin
            m = MINSEC_MAX;
            h = (h == 8'h00 || h > hmax) ? hmax : h - 8'h01;
          end
        end
      end
    end
    return {h, 2'b00, m, 2'b00, s, 1'b0, f};
  endfunction

endpackage

// File: verification/tb.sv
/*
  Self-checking bench for the dual general timers: register reset values and
  access kinds, period of every source code except timer B codes 5 to 7 and of every prescale except timer B divide by 32768, interrupt clear,
  and capture in binary and time formats.
  Assumes the zero-wait AHB-Lite slave and the timing given in the hand-over.
*/
`timescale 1ns/100ps

module tb;
  import dual_timers_pkg::*;

  // ==========================================================================
  // Signals
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sec_clk = 1'b0;
  logic        osc_clk = 1'b0;
  logic        pin_in = 1'b0;
  logic [31:0] event_sources = 32'h0000_0000;
  logic        irq_a;
  logic        irq_b;
  logic        adc_trig_a;
  logic        adc_trig_b;
  logic [31:0] exp_q[$];
  logic        rd_pend = 1'b0;
  int          src_cnt = 0;
  int          err_total = 0;
  int          tests_run = 0;
  int          ld;
  logic [31:0] r;
  logic [31:0] ro_addr[5] = '{A_VAL_ADDR, B_VAL_ADDR, B_CAP_ADDR, 32'hFFFF_0310, A_CLR_ADDR};
  logic [31:0] ro_exp[5] = '{32'h0000_FFFF, B_VAL_RST, 32'h0000_0000, 32'h0000_0000,
                             32'h0000_0000};

  always #2.5 clk = ~clk;

  dual_timers uut (
    .clk                 (clk),
    .nrst                (nrst),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hreadyout),
    .hrdata              (hrdata),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .second_system_clock (sec_clk),
    .osc_32k             (osc_clk),
    .external_count_pin  (pin_in),
    .event_sources       (event_sources),
    .irq_a               (irq_a),
    .irq_b               (irq_b),
    .adc_trig_a          (adc_trig_a),
    .adc_trig_b          (adc_trig_b)
  );

  // ==========================================================================
  // Slow sources: rising edge every 6, 4 and 10 core cycles
  always @(posedge clk) begin
    src_cnt <= src_cnt + 1;
    sec_clk <= (src_cnt % 6) < 3;
    osc_clk <= (src_cnt % 4) < 2;
    pin_in  <= (src_cnt % 10) < 5;
  end

  // ==========================================================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d, comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Read data stands only in the data phase, so it is taken at that edge
  always @(posedge clk) begin
    if (rd_pend && hreadyout === 1'b1) begin
      if (exp_q.size() > 0) chk(hrdata, exp_q.pop_front());
      chk({31'b0, hresp}, 32'h0000_0000);
      rd_pend = 1'b0;
    end
    if (hreadyout === 1'b1) rd_pend = hsel && htrans[1] && !hwrite;
  end

  // ==========================================================================
  // Bus tasks: one idle cycle first keeps a read clear of the last write
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= 1'b0;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  // ==========================================================================
  // Period between two trigger pulses, then stop, check and clear the irq
  task automatic run(input logic [31:0] base, input logic [31:0] ctl,
                     input logic [31:0] ldv, input int exp);
    int   n;
    int   t1;
    int   t2;
    logic b;
    b  = (base == B_LOAD_ADDR);
    t1 = -1;
    t2 = -1;
    wr(base, ldv);
    wr(base + 32'h8, ctl);
    for (n = 0; n < 4 * exp + 300 && t2 < 0; n++) begin
      @(posedge clk);
      #1;
      if ((b ? adc_trig_b : adc_trig_a) === 1'b1) begin
        if (t1 < 0) t1 = n;
        else t2 = n;
      end
    end
    chk(32'(t2 - t1), 32'(exp));
    wr(base + 32'h8, 32'h0000_0000);
    #1 chk({31'b0, b ? irq_b : irq_a}, {31'b0, exp > 0});
    wr(base + 32'hC, $urandom);
    #1 chk({31'b0, b ? irq_b : irq_a}, 32'h0000_0000);
  endtask

  // Event n rises j cycles after enable; capture holds the value then
  task automatic cap(input logic [31:0] ctl, input logic [31:0] ldv, input int j,
                     input logic [31:0] exp);
    logic [31:0] n;
    n = $urandom_range(31);
    @(posedge clk);
    event_sources <= $urandom & ~(32'h1 << n);
    wr(B_LOAD_ADDR, ldv);
    wr(B_CTL_ADDR, ctl | 32'h0002_0080 | (n << 12));
    repeat (j) @(posedge clk);
    event_sources[n] <= 1'b1;
    wr(B_CTL_ADDR, 32'h0000_0000);
    rd(B_CAP_ADDR, exp);
    wr(B_CLR_ADDR, 32'h0000_0000);
    event_sources <= 32'h0000_0000;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'h2eb5));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd(A_LOAD_ADDR, 32'h0000_0000);
    rd(A_CTL_ADDR, 32'h0000_0000);
    rd(B_LOAD_ADDR, 32'h0000_0000);
    rd(B_CTL_ADDR, 32'h0000_0000);
    for (int i = 0; i < 4; i++) rd(ro_addr[i], ro_exp[i]);
    for (int i = 0; i < 5; i++) wr(ro_addr[i], $urandom);
    for (int i = 0; i < 4; i++) rd(ro_addr[i], ro_exp[i]);
    r = $urandom;
    wr(A_LOAD_ADDR, r);
    rd(A_LOAD_ADDR, {16'h0000, r[15:0]});
    wr(B_LOAD_ADDR, r);
    rd(B_LOAD_ADDR, r);
    r = $urandom & 32'hFFFF_FF7F;
    wr(A_CTL_ADDR, r);
    rd(A_CTL_ADDR, r & 32'h0000_00FC);
    wr(B_CTL_ADDR, r);
    rd(B_CTL_ADDR, r & B_CTL_MASK);
    rd(A_VAL_ADDR, 32'h0000_FFFF);
    ld = 2 + $urandom_range(3);
    run(A_LOAD_ADDR, 32'h0000_00C0, ld, ld + 1);
    run(A_LOAD_ADDR, 32'h0000_00C4, ld, 16 * (ld + 1));
    run(A_LOAD_ADDR, 32'h0000_00C8, ld, 256 * (ld + 1));
    run(A_LOAD_ADDR, 32'h0000_00CC, ld, ld + 1);
    run(A_LOAD_ADDR, 32'h0000_00D0, ld, 6 * (ld + 1));
    run(A_LOAD_ADDR, 32'h0000_00E0, ld, 4 * (ld + 1));
    run(A_LOAD_ADDR, 32'h0000_00F0, ld, 0);
    run(B_LOAD_ADDR, 32'h0000_00C0, ld, ld + 1);
    run(B_LOAD_ADDR, 32'h0000_01C0, 32'hFFFF_FFFC, 4);
    run(B_LOAD_ADDR, 32'h0000_01C4, 32'hFFFF_FFFC, 64);
    run(B_LOAD_ADDR, 32'h0000_01C8, 32'hFFFF_FFFC, 1024);
    run(B_LOAD_ADDR, 32'h0000_01C5, 32'hFFFF_FFFC, 4);
    run(B_LOAD_ADDR, 32'h0000_03C0, 32'hFFFF_FFFC, 16);
    run(B_LOAD_ADDR, 32'h0000_05C0, 32'hFFFF_FFFC, 24);
    run(B_LOAD_ADDR, 32'h0000_07C0, 32'hFFFF_FFFC, 40);
    run(B_LOAD_ADDR, 32'h0000_09C0, 32'hFFFF_FFFC, 0);
    run(B_LOAD_ADDR, 32'h0000_03E8, 32'h173B_3B7C, 4096);
    cap(32'h0000_0100, 32'hFFFF_FFFD, 5, 32'h0000_0002);
    cap(32'h0000_0120, 32'h173B_3B7E, 3, 32'h0000_0001);
    cap(32'h0000_0130, 32'h173B_3B7F, 1, 32'h1800_0000);
    cap(32'h0000_0020, 32'h0100_0000, 1, 32'h003B_3B7F);
    cap(32'h0000_0020, 32'h0000_0201, 3, 32'h0000_017E);
    repeat (4) @(posedge clk);
    finish_test();
  end

  // Watchdog well above the longest expected run
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    finish_test();
  end

endmodule // tb
